// ---- src/sksd_regs.svh ----
// Register offsets, field positions and reset values of the segment decoder.
`ifndef SKSD_REGS_SVH
`define SKSD_REGS_SVH
// ----------------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------------
`define SKSD_CTRL      8'h00
`define SKSD_VA_LO     8'h04
`define SKSD_VA_HI     8'h08
`define SKSD_BASE      8'h0C
`define SKSD_OFS       8'h10
`define SKSD_CMD       8'h14
`define SKSD_RESULT    8'h18
`define SKSD_XLAT_LO   8'h1C
`define SKSD_XLAT_HI   8'h20
`define SKSD_STATUS    8'h24
`define SKSD_MASK      8'h28
// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define SKSD_CTRL_PLF  0
`define SKSD_CTRL_EXL  2
`define SKSD_CTRL_ERL  3
`define SKSD_CTRL_SW   4
`define SKSD_CTRL_KW   5
`define SKSD_CTRL_TAG  8
`define SKSD_CMD_DEC   0
`define SKSD_CMD_CALC  1
`define SKSD_CMD_EXC   2
`define SKSD_CMD_RET   3
`define SKSD_ST_DONE   0
`define SKSD_ST_AERR   1
`define SKSD_ST_OVF    2
`define SKSD_ST_EXC    3
`define SKSD_RES_MAP   4
`define SKSD_RES_CACHE 5
`define SKSD_RES_WIDE  6
`define SKSD_RES_ERR   7
`define SKSD_RES_OVF   8
`define SKSD_RES_TAG   16
// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define SKSD_RST_PLF   2'h0
`define SKSD_RST_ERL   1'h1
`endif

// ---- src/sksd_pkg.sv ----
// Types and shared mode decoding of the segment decoder.
package sksd_pkg;
  typedef enum logic [1:0] {MODE_USER, MODE_SUPER, MODE_KERNEL} sksd_mode_e;
  typedef enum logic [3:0] {
    SEG_NONE, SEG_USER, SEG_SUPER, SEG_COMPAT_SUPER, SEG_KERN_USER,
    SEG_KERN_CACHED, SEG_KERN_UNCACHED, SEG_KERN_MAPPED, SEG_KERN_PHYS
  } sksd_seg_e;

  typedef struct packed {
    logic      done;
    sksd_seg_e seg;
    logic      mapped;
    logic      cached;
    logic      wide;
    logic      err;
    logic [71:0] taddr;
  } sksd_dec_s;

  typedef struct packed {
    logic [1:0]  plf;
    logic        exception_level_bit;
    logic        error_level_bit;
    logic        sw;
    logic        kw;
    logic [7:0]  tag;
    logic [63:0] vaddr;
    logic [31:0] base;
    logic [15:0] ofs;
    sksd_seg_e   seg;
    logic        mapped;
    logic        cached;
    logic        wide;
    logic        err;
    logic        ovf;
    logic [71:0] xaddr;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
    logic        xlat_valid;
    logic        addr_err;
    logic        kernel;
  } sksd_top_s;

  // Kernel wins over any field value; supervisor needs both level bits clear.
  function automatic sksd_mode_e sksd_mode_of(input logic [1:0] plf, input logic exception_level_bit,
                                              input logic error_level_bit);
    if (exception_level_bit || error_level_bit || plf == 2'h0) begin
      return MODE_KERNEL;
    end else if (plf == 2'h1) begin
      return MODE_SUPER;
    end else begin
      return MODE_USER;
    end
  endfunction : sksd_mode_of
endpackage : sksd_pkg

// ---- src/sksd_decode.sv ----
// Segment decoder with registered result, one cycle after start.
module sksd_decode (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               start,
  input  sksd_pkg::sksd_mode_e    mode,
  input  wire logic               sup_wide,
  input  wire logic               kern_wide,
  input  wire logic [63:0]        vaddr,
  input  wire logic [7:0]         tag,
  output sksd_pkg::sksd_dec_s     res
);
  sksd_pkg::sksd_dec_s r;
  sksd_pkg::sksd_dec_s next_r;
  logic        wide;
  logic [63:0] va;
  logic        mid_zero;
  logic        top_ones;

  assign wide     = (mode == sksd_pkg::MODE_KERNEL) ? kern_wide : sup_wide;
  assign va       = wide ? vaddr : {{32{vaddr[31]}}, vaddr[31:0]};
  assign mid_zero = (va[61:40] == 22'h000000);
  assign top_ones = &va[63:32];
  assign res      = r;

  always_comb begin
    next_r      = r;
    next_r.done = start;
    if (start) begin
      next_r.seg    = sksd_pkg::SEG_NONE;
      next_r.mapped = 1'b1;
      next_r.cached = 1'b0;
      next_r.wide   = wide;
      next_r.err    = 1'b0;
      next_r.taddr  = {tag, va};
      case (mode)
        sksd_pkg::MODE_SUPER: begin
          if (!wide && !va[31]) begin
            next_r.seg = sksd_pkg::SEG_USER;
          end else if (!wide && va[31:29] == 3'h6) begin
            next_r.seg = sksd_pkg::SEG_SUPER;
          end else if (wide && va[63:62] == 2'h0 && mid_zero) begin
            next_r.seg = sksd_pkg::SEG_USER;
          end else if (wide && va[63:62] == 2'h1 && mid_zero) begin
            next_r.seg = sksd_pkg::SEG_SUPER;
          end else if (wide && top_ones && va[31:29] == 3'h6) begin
            next_r.seg = sksd_pkg::SEG_COMPAT_SUPER;
          end else begin
            next_r.err = 1'b1;
          end
        end
        sksd_pkg::MODE_KERNEL: begin
          if ((!wide || top_ones) && va[31:29] == 3'h4) begin
            next_r.seg    = sksd_pkg::SEG_KERN_CACHED;
            next_r.mapped = 1'b0;
            next_r.cached = 1'b1;
          end else if ((!wide || top_ones) && va[31:29] == 3'h5) begin
            next_r.seg    = sksd_pkg::SEG_KERN_UNCACHED;
            next_r.mapped = 1'b0;
          end else if ((!wide || top_ones) && va[31:29] == 3'h6) begin
            next_r.seg = wide ? sksd_pkg::SEG_COMPAT_SUPER : sksd_pkg::SEG_SUPER;
          end else if ((!wide || top_ones) && va[31:29] == 3'h7) begin
            next_r.seg = sksd_pkg::SEG_KERN_MAPPED;
          end else if (!wide) begin
            next_r.seg = sksd_pkg::SEG_KERN_USER;
          end else if (va[63:62] == 2'h0 && mid_zero) begin
            next_r.seg = sksd_pkg::SEG_KERN_USER;
          end else if (va[63:62] == 2'h1 && mid_zero) begin
            next_r.seg = sksd_pkg::SEG_SUPER;
          end else if (va[63:62] == 2'h2) begin
            next_r.seg    = sksd_pkg::SEG_KERN_PHYS;
            next_r.mapped = 1'b0;
            next_r.cached = (va[61:59] != 3'h2);
          end else if (va[63:62] == 2'h3 && mid_zero) begin
            next_r.seg = sksd_pkg::SEG_KERN_MAPPED;
          end else begin
            next_r.err = 1'b1;
          end
        end
        default: begin
          next_r.err = 1'b1;
        end
      endcase
      if (next_r.err) begin
        next_r.mapped = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  property p_sseg;
    @(posedge pclk) disable iff (!presetn)
    start && mode == sksd_pkg::MODE_SUPER && !sup_wide && vaddr[31:29] == 3'h6
      |=> r.seg == sksd_pkg::SEG_SUPER && r.mapped && !r.err;
  endproperty
  a_sseg: assert property (p_sseg) else $error("32-bit supervisor segment missed");

  property p_kwide;
    @(posedge pclk) disable iff (!presetn)
    start && mode == sksd_pkg::MODE_KERNEL |=> r.wide == $past(kern_wide);
  endproperty
  a_kwide: assert property (p_kwide) else $error("kernel miss handler width wrong");

  property p_kernel_unmapped_uncached_segment;
    @(posedge pclk) disable iff (!presetn)
    start && mode == sksd_pkg::MODE_KERNEL && !kern_wide && vaddr[31:29] == 3'h5
      |=> r.seg == sksd_pkg::SEG_KERN_UNCACHED && !r.mapped && !r.cached;
  endproperty
  a_kernel_unmapped_uncached_segment: assert property (p_kernel_unmapped_uncached_segment) else $error("uncached kernel segment wrong");

  property p_sext;
    @(posedge pclk) disable iff (!presetn)
    start && !wide |=> r.taddr[63:32] == {32{$past(vaddr[31])}};
  endproperty
  a_sext: assert property (p_sext) else $error("32-bit address not sign extended");
endmodule : sksd_decode

// ---- src/sksd_top.sv ----
// Supervisor and kernel segment decoder with APB registers and interrupt.
`include "sksd_regs.svh"
module sksd_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             kernel_mode,
  output logic             xlat_valid,
  output logic      [71:0] xlat_addr,
  output logic             xlat_wide_miss,
  output logic             addr_error
);
  // --------------------------------------------------------------------------
  // State and helpers.
  // --------------------------------------------------------------------------
  sksd_pkg::sksd_top_s r;
  sksd_pkg::sksd_top_s next_r;
  sksd_pkg::sksd_dec_s dec;
  sksd_pkg::sksd_mode_e mode;
  logic        acc;
  logic        wr;
  logic        cmd_wr;
  logic        cmd_dec;
  logic        cmd_calc;
  logic        cmd_exc;
  logic        cmd_ret;
  logic [31:0] sum;
  logic        ovf_now;
  logic [63:0] dec_va;
  logic [3:0]  st_set;

  assign mode     = sksd_pkg::sksd_mode_of(r.plf, r.exception_level_bit, r.error_level_bit);
  assign acc      = psel && penable && !r.pready;
  assign wr       = psel && penable && r.pready && pwrite;
  assign cmd_wr   = wr && paddr == `SKSD_CMD;
  assign cmd_dec  = cmd_wr && pwdata[`SKSD_CMD_DEC];
  assign cmd_calc = cmd_wr && pwdata[`SKSD_CMD_CALC];
  assign cmd_exc  = cmd_wr && pwdata[`SKSD_CMD_EXC];
  assign cmd_ret  = cmd_wr && pwdata[`SKSD_CMD_RET] && !pwdata[`SKSD_CMD_EXC];
  assign sum      = r.base + {{16{r.ofs[15]}}, r.ofs};
  assign ovf_now  = (r.ofs[15] == r.base[31]) && (sum[31] != r.base[31]);
  assign dec_va   = cmd_calc ? {{32{sum[31]}}, sum} : r.vaddr;

  // Address map check, used for the error answer; the read mux decodes paddr itself.
  function automatic logic sksd_known(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= `SKSD_MASK;
  endfunction : sksd_known

  // --------------------------------------------------------------------------
  // Segment decoder.
  // --------------------------------------------------------------------------
  sksd_decode u_dec (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (cmd_dec || cmd_calc),
    .mode      (mode),
    .sup_wide  (r.sw),
    .kern_wide (r.kw),
    .vaddr     (dec_va),
    .tag       (r.tag),
    .res       (dec)
  );

  // --------------------------------------------------------------------------
  // Next state.
  // --------------------------------------------------------------------------
  always_comb begin
    next_r            = r;
    next_r.pready     = acc;
    next_r.pslverr    = 1'b0;
    next_r.xlat_valid = 1'b0;
    next_r.addr_err   = 1'b0;
    st_set            = 4'h0;
    if (acc) begin
      next_r.pslverr = !sksd_known(paddr);
      if (paddr == `SKSD_CTRL) begin
        next_r.prdata = {16'h0000, r.tag, 2'h0, r.kw, r.sw, r.error_level_bit, r.exception_level_bit, r.plf};
      end else if (paddr == `SKSD_VA_LO) begin
        next_r.prdata = r.vaddr[31:0];
      end else if (paddr == `SKSD_VA_HI) begin
        next_r.prdata = r.vaddr[63:32];
      end else if (paddr == `SKSD_BASE) begin
        next_r.prdata = r.base;
      end else if (paddr == `SKSD_OFS) begin
        next_r.prdata = {16'h0000, r.ofs};
      end else if (paddr == `SKSD_RESULT) begin
        next_r.prdata = {8'h00, r.xaddr[71:64], 7'h00, r.ovf, r.err, r.wide,
                         r.cached, r.mapped, r.seg};
      end else if (paddr == `SKSD_XLAT_LO) begin
        next_r.prdata = r.xaddr[31:0];
      end else if (paddr == `SKSD_XLAT_HI) begin
        next_r.prdata = r.xaddr[63:32];
      end else if (paddr == `SKSD_STATUS) begin
        next_r.prdata = {28'h0000000, r.status};
      end else if (paddr == `SKSD_MASK) begin
        next_r.prdata = {28'h0000000, r.mask};
      end else begin
        next_r.prdata = 32'h00000000;
      end
    end
    if (wr) begin
      if (paddr == `SKSD_CTRL) begin
        next_r.plf = pwdata[`SKSD_CTRL_PLF +: 2];
        next_r.exception_level_bit = pwdata[`SKSD_CTRL_EXL];
        next_r.error_level_bit = pwdata[`SKSD_CTRL_ERL];
        next_r.sw  = pwdata[`SKSD_CTRL_SW];
        next_r.kw  = pwdata[`SKSD_CTRL_KW];
        next_r.tag = pwdata[`SKSD_CTRL_TAG +: 8];
      end else if (paddr == `SKSD_VA_LO) begin
        next_r.vaddr[31:0] = pwdata;
      end else if (paddr == `SKSD_VA_HI) begin
        next_r.vaddr[63:32] = pwdata;
      end else if (paddr == `SKSD_BASE) begin
        next_r.base = pwdata;
      end else if (paddr == `SKSD_OFS) begin
        next_r.ofs = pwdata[15:0];
      end else if (paddr == `SKSD_STATUS) begin
        next_r.status = r.status & ~pwdata[3:0];
      end else if (paddr == `SKSD_MASK) begin
        next_r.mask = pwdata[3:0];
      end
    end
    // Exception entry sets the level bit and beats a same-cycle control write.
    if (cmd_exc) begin
      next_r.exception_level_bit             = 1'b1;
      st_set[`SKSD_ST_EXC]   = 1'b1;
    end else if (cmd_ret) begin
      // Leaving the level bits clear restores the field-selected mode.
      if (r.error_level_bit) begin
        next_r.error_level_bit = 1'b0;
      end else begin
        next_r.exception_level_bit = 1'b0;
      end
    end
    if (cmd_calc) begin
      next_r.vaddr = {{32{sum[31]}}, sum};
      next_r.ovf   = ovf_now;
    end else if (cmd_dec) begin
      next_r.ovf = 1'b0;
    end
    if (dec.done) begin
      next_r.seg        = dec.seg;
      next_r.mapped     = dec.mapped;
      next_r.cached     = dec.cached;
      next_r.wide       = dec.wide;
      next_r.err        = dec.err || r.ovf;
      next_r.xaddr      = dec.taddr;
      next_r.addr_err   = dec.err || r.ovf;
      next_r.xlat_valid = dec.mapped && !dec.err && !r.ovf;
      st_set[`SKSD_ST_DONE] = 1'b1;
      st_set[`SKSD_ST_AERR] = dec.err || r.ovf;
      st_set[`SKSD_ST_OVF]  = r.ovf;
    end
    // Hardware sets win over a same-cycle write-one-to-clear.
    next_r.status = next_r.status | st_set;
    next_r.irq    = |(next_r.status & next_r.mask);
    next_r.kernel = sksd_pkg::sksd_mode_of(next_r.plf, next_r.exception_level_bit,
                                           next_r.error_level_bit) == sksd_pkg::MODE_KERNEL;
  end

  // --------------------------------------------------------------------------
  // State register.
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r     <= '0;
      r.plf <= `SKSD_RST_PLF;
      r.error_level_bit <= `SKSD_RST_ERL;
      r.kernel <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign prdata         = r.prdata;
  assign pready         = r.pready;
  assign pslverr        = r.pslverr;
  assign irq            = r.irq;
  assign kernel_mode    = r.kernel;
  assign xlat_valid     = r.xlat_valid;
  assign xlat_addr      = r.xaddr;
  assign xlat_wide_miss = r.wide;
  assign addr_error     = r.addr_err;

  // --------------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------------
  property p_kernel;
    @(posedge pclk) disable iff (!presetn)
    kernel_mode == (r.plf == 2'h0 || r.exception_level_bit || r.error_level_bit);
  endproperty
  a_kernel: assert property (p_kernel) else $error("kernel flag wrong");

  property p_super;
    @(posedge pclk) disable iff (!presetn)
    r.plf == 2'h1 && !r.exception_level_bit && !r.error_level_bit |-> mode == sksd_pkg::MODE_SUPER && !kernel_mode;
  endproperty
  a_super: assert property (p_super) else $error("supervisor mode not taken");

  property p_exc;
    @(posedge pclk) disable iff (!presetn)
    cmd_exc |=> r.exception_level_bit && kernel_mode && r.status[`SKSD_ST_EXC];
  endproperty
  a_exc: assert property (p_exc) else $error("exception did not enter kernel");

  property p_ret;
    @(posedge pclk) disable iff (!presetn)
    cmd_ret && !r.error_level_bit && r.exception_level_bit |=> !r.exception_level_bit && r.plf == $past(r.plf)
      && kernel_mode == ($past(r.plf) == 2'h0);
  endproperty
  a_ret: assert property (p_ret) else $error("return did not restore mode");

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
    cmd_dec || cmd_calc |=> ##1 (r.status[`SKSD_ST_DONE] && (!xlat_valid || !addr_error));
  endproperty
  a_answer: assert property (p_answer) else $error("decode gave no result");

  property p_ovf;
    @(posedge pclk) disable iff (!presetn)
    cmd_calc && ovf_now |=> ##1 (addr_error && !xlat_valid && r.status[`SKSD_ST_OVF]);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflowed address was translated");

  property p_tag;
    @(posedge pclk) disable iff (!presetn)
    (cmd_dec || cmd_calc) && !(wr && paddr == `SKSD_CTRL) ##2 xlat_valid
      |-> xlat_addr[71:64] == $past(r.tag, 2);
  endproperty
  a_tag: assert property (p_tag) else $error("space tag missing on request");

  property p_narrow;
    @(posedge pclk) disable iff (!presetn)
    cmd_dec && mode == sksd_pkg::MODE_KERNEL && !r.kw |=> ##1 !xlat_wide_miss;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow kernel used wide handler");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready held over two cycles");

  property p_xsuseg;
    @(posedge pclk) disable iff (!presetn)
    cmd_dec && !cmd_calc && mode == sksd_pkg::MODE_SUPER && r.sw
      && r.vaddr[63:40] == 24'h000000
      |=> ##1 (xlat_valid && r.seg == sksd_pkg::SEG_USER);
  endproperty
  a_xsuseg: assert property (p_xsuseg) else $error("wide user segment missed");

  property p_xsseg;
    @(posedge pclk) disable iff (!presetn)
    cmd_dec && !cmd_calc && mode == sksd_pkg::MODE_SUPER && r.sw
      && r.vaddr[63:62] == 2'h1 && r.vaddr[61:40] == 22'h000000
      |=> ##1 (xlat_valid && r.seg == sksd_pkg::SEG_SUPER);
  endproperty
  a_xsseg: assert property (p_xsseg) else $error("wide supervisor segment missed");

  property p_csseg;
    @(posedge pclk) disable iff (!presetn)
    cmd_dec && !cmd_calc && mode == sksd_pkg::MODE_SUPER && r.sw
      && (&r.vaddr[63:32]) && r.vaddr[31:29] == 3'h6
      |=> ##1 (xlat_valid && r.seg == sksd_pkg::SEG_COMPAT_SUPER);
  endproperty
  a_csseg: assert property (p_csseg) else $error("compatibility segment missed");

  property p_wide;
    @(posedge pclk) disable iff (!presetn)
    cmd_dec && mode == sksd_pkg::MODE_KERNEL && r.kw |=> ##1 xlat_wide_miss;
  endproperty
  a_wide: assert property (p_wide) else $error("wide kernel used narrow handler");

  property p_aerr;
    @(posedge pclk) disable iff (!presetn)
    addr_error |-> !xlat_valid;
  endproperty
  a_aerr: assert property (p_aerr) else $error("address error still translated");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    irq == (|(r.status & r.mask));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule : sksd_top

// ---- testbench/sksd_tlb_model.sv ----
// Translation buffer side model that counts every request of the decoder and keeps the last one.
module sksd_tlb_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        xlat_valid,
  input  wire logic [71:0] xlat_addr,
  input  wire logic        xlat_wide_miss,
  input  wire logic        addr_error,
  output int               n_req,
  output int               n_err,
  output logic      [71:0] last_addr,
  output logic             last_wide
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------------
  // Request capture.
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_req     <= 0;
      n_err     <= 0;
      last_addr <= 72'h0;
      last_wide <= 1'h0;
    end else begin
      if (xlat_valid) begin
        n_req     <= n_req + 1;
        last_addr <= xlat_addr;
        last_wide <= xlat_wide_miss;
      end
      if (addr_error) begin
        n_err <= n_err + 1;
      end
    end
  end
endmodule : sksd_tlb_model

// ---- testbench/tb_sksd_top.sv ----
// Self-checking bench of the segment decoder with its register bus.
`include "sksd_regs.svh"
module tb_sksd_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [63:0] va;
    logic [3:0]  seg;
    logic        map;
    logic        wide;
    logic        err;
  } sksd_row_s;
  localparam sksd_row_s ROWS [19] = '{
    '{16'h5A01, 64'h0000_0000_C000_1234, 4'h2, 1'h1, 1'h0, 1'h0},
    '{16'h5A01, 64'h0000_0000_8000_0000, 4'h0, 1'h0, 1'h0, 1'h1},
    '{16'h5A11, 64'h0000_00FF_FFFF_FFF0, 4'h1, 1'h1, 1'h1, 1'h0},
    '{16'h5A11, 64'h4000_0012_0000_0000, 4'h2, 1'h1, 1'h1, 1'h0},
    '{16'h5A11, 64'hFFFF_FFFF_C000_0000, 4'h3, 1'h1, 1'h1, 1'h0},
    '{16'h5A11, 64'h8000_0000_0000_0000, 4'h0, 1'h0, 1'h0, 1'h1},
    '{16'h5A00, 64'h0000_0000_8000_0000, 4'h5, 1'h0, 1'h0, 1'h0},
    '{16'h5A00, 64'h0000_0000_A000_0000, 4'h6, 1'h0, 1'h0, 1'h0},
    '{16'h5A00, 64'h0000_0000_7FFF_FFFF, 4'h4, 1'h1, 1'h0, 1'h0},
    '{16'h5A00, 64'h0000_0000_E000_0000, 4'h7, 1'h1, 1'h0, 1'h0},
    '{16'h3C20, 64'h0000_0000_0000_1000, 4'h4, 1'h1, 1'h1, 1'h0},
    '{16'h5A05, 64'h0000_0000_C000_0000, 4'h2, 1'h1, 1'h0, 1'h0},
    '{16'h5A09, 64'h0000_0000_9000_0000, 4'h5, 1'h0, 1'h0, 1'h0},
    '{16'h5A02, 64'h0000_0000_0000_1000, 4'h0, 1'h0, 1'h0, 1'h1},
    '{16'h5A20, 64'h9000_0000_0000_0000, 4'h8, 1'h0, 1'h0, 1'h0},
    '{16'h5A20, 64'hC000_0000_0000_0000, 4'h7, 1'h1, 1'h1, 1'h0},
    '{16'h5A20, 64'hFFFF_FFFF_A000_0000, 4'h6, 1'h0, 1'h0, 1'h0},
    '{16'h5A20, 64'h4000_0100_0000_0000, 4'h0, 1'h0, 1'h0, 1'h1},
    '{16'h5A20, 64'h4000_0000_0000_0100, 4'h2, 1'h1, 1'h1, 1'h0}
  };
  logic        pclk    = 1'h0;
  logic        presetn = 1'h0;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        kernel_mode;
  logic        xlat_valid;
  logic [71:0] xlat_addr;
  logic        xlat_wide_miss;
  logic        addr_error;
  int          tlb_req;
  int          tlb_err;
  logic [71:0] tlb_addr;
  logic        tlb_wide;
  int          errors     = 0;
  int          n_compared = 0;
  int          nr;
  int          ne;
  logic [31:0] rd;
  logic        se;
  logic [63:0] ext;

  always #50 pclk = ~pclk;

  sksd_top u_sksd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .kernel_mode(kernel_mode), .xlat_valid(xlat_valid),
    .xlat_addr(xlat_addr), .xlat_wide_miss(xlat_wide_miss), .addr_error(addr_error));

  sksd_tlb_model u_sksd_tlb_model (.pclk(pclk), .presetn(presetn), .xlat_valid(xlat_valid),
    .xlat_addr(xlat_addr), .xlat_wide_miss(xlat_wide_miss), .addr_error(addr_error),
    .n_req(tlb_req), .n_err(tlb_err), .last_addr(tlb_addr), .last_wide(tlb_wide));

  // --------------------------------------------------------------------------
  // Shared tasks.
  // --------------------------------------------------------------------------
  task automatic print_verdict();
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [71:0] seen, input logic [71:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (i == 20) begin
      errors++;
      print_verdict();
    end
    rd = prdata;
    se = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task automatic dec(input logic [15:0] ctrl, input logic [63:0] va, input logic [3:0] cmd);
    nr = tlb_req;
    ne = tlb_err;
    apb(1'h1, `SKSD_CTRL, {16'h0000, ctrl});
    apb(1'h1, `SKSD_VA_LO, va[31:0]);
    apb(1'h1, `SKSD_VA_HI, va[63:32]);
    apb(1'h1, `SKSD_CMD, {28'h0, cmd});
    repeat (3) @(posedge pclk);
  endtask : dec

  // --------------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk("kernel mode", kernel_mode, 72'h1);
    apb(1'h0, `SKSD_CTRL, 32'h0);
    chk("control", rd, 72'h8);
    foreach (ROWS[k]) begin
      dec(ROWS[k].ctrl, ROWS[k].va, 4'h1);
      apb(1'h0, `SKSD_RESULT, 32'h0);
      ext = ROWS[k].wide ? ROWS[k].va : {{32{ROWS[k].va[31]}}, ROWS[k].va[31:0]};
      chk("segment", rd[3:0], ROWS[k].seg);
      chk("mapped", rd[4], ROWS[k].map);
      chk("error", tlb_err - ne, ROWS[k].err);
      chk("requests", tlb_req - nr, ROWS[k].map);
      if (ROWS[k].map) begin
        chk("translated", tlb_addr, {ROWS[k].ctrl[15:8], ext});
        chk("wide miss", tlb_wide, ROWS[k].wide);
      end
      chk("kernel mode", kernel_mode,
          (ROWS[k].ctrl[1:0] == 2'h0) | ROWS[k].ctrl[2] | ROWS[k].ctrl[3]);
    end
    apb(1'h0, 8'h2C, 32'h0);
    chk("unmapped error", se, 72'h1);
    chk("unmapped data", rd, 72'h0);
    apb(1'h1, `SKSD_BASE, 32'h7FFF_FFF0);
    apb(1'h1, `SKSD_OFS, 32'h0000_0020);
    dec(16'h5A00, 64'h0, 4'h2);
    apb(1'h0, `SKSD_RESULT, 32'h0);
    chk("overflow", rd[8], 72'h1);
    chk("overflow error", tlb_err - ne, 72'h1);
    apb(1'h1, `SKSD_BASE, 32'hC000_0000);
    apb(1'h1, `SKSD_OFS, 32'h0000_FFF0);
    dec(16'h5A00, 64'h0, 4'h2);
    apb(1'h0, `SKSD_RESULT, 32'h0);
    chk("no overflow", {rd[8], rd[3:0]}, 72'h6);
    dec(16'h5A01, 64'h0, 4'h4);
    chk("exception entry", kernel_mode, 72'h1);
    apb(1'h1, `SKSD_CMD, 32'h8);
    repeat (3) @(posedge pclk);
    chk("after return", kernel_mode, 72'h0);
    apb(1'h0, `SKSD_CTRL, 32'h0);
    chk("restored mode", rd[3:0], 72'h1);
    apb(1'h1, `SKSD_CMD, 32'hC);
    repeat (3) @(posedge pclk);
    chk("return ignored", kernel_mode, 72'h1);
    apb(1'h1, `SKSD_STATUS, 32'hF);
    apb(1'h1, `SKSD_MASK, 32'h2);
    dec(16'h5A01, 64'h0000_0000_8000_0000, 4'h1);
    chk("irq raised", irq, 72'h1);
    apb(1'h1, `SKSD_STATUS, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq cleared", irq, 72'h0);
    apb(1'h1, `SKSD_MASK, 32'h0);
    dec(16'h5A01, 64'h0000_0000_8000_0000, 4'h1);
    chk("irq masked", irq, 72'h0);
    apb(1'h0, `SKSD_STATUS, 32'h0);
    chk("status sticky", rd[1], 72'h1);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk("reset kernel", kernel_mode, 72'h1);
    apb(1'h0, `SKSD_STATUS, 32'h0);
    chk("reset status", rd, 72'h0);
    apb(1'h0, `SKSD_CTRL, 32'h0);
    chk("reset control", rd, 72'h8);
    print_verdict();
  end
endmodule : tb_sksd_top
